// file: inc/mcu_exec_regs.vh
`ifndef MCU_EXEC_REGS_VH
`define MCU_EXEC_REGS_VH

// register byte offsets
`define OFS_ISSUE      12'h000
`define OFS_STATUS     12'h004
`define OFS_FLAGS      12'h008
`define OFS_WORKING    12'h00C
`define OFS_PC         12'h010
`define OFS_STACK      12'h014
`define OFS_WATCHDOG   12'h018
`define OFS_CTRL       12'h01C
`define MEM_BASE_HI    3'h1

// issue word fields
`define ISS_OP_HI      4
`define ISS_OP_LO      0
`define ISS_ADDR_HI    14
`define ISS_ADDR_LO    8
`define ISS_IMM_HI     23
`define ISS_IMM_LO     16
`define ISS_TGT_HI     26
`define ISS_TGT_LO     16

// flag register bits
`define FLG_CARRY      0
`define FLG_HALF       1
`define FLG_NULL       2
`define FLG_TIMEOUT    3
`define FLG_SLEEP      4
`define FLG_IRQ_EN     5

// control register bits and reset value
`define CTL_WD_EN      0
`define CTL_WAKE       1
`define CTL_RESET      1'b1

// data memory index that aliases the program counter low byte
`define PC_LOW_INDEX   7'h02

// timing: system clocks per instruction cycle
`define INSN_CLKS      4'h4
`define LAST_ONE       (`INSN_CLKS - 4'h1)
`define LAST_TWO       (`INSN_CLKS + `INSN_CLKS - 4'h1)

// bcd adjust constants
`define BCD_LIMIT      5'h09
`define BCD_STEP       5'h06

// operation codes
`define OP_KICK        5'h00
`define OP_PREKICK_A   5'h01
`define OP_PREKICK_B   5'h02
`define OP_INVERT      5'h03
`define OP_INVERT_W    5'h04
`define OP_BCD_ADJUST  5'h05
`define OP_SUB_ONE     5'h06
`define OP_SUB_ONE_W   5'h07
`define OP_ADD_ONE     5'h08
`define OP_ADD_ONE_W   5'h09
`define OP_SLEEP       5'h0A
`define OP_BRANCH      5'h0B
`define OP_COPY_MW     5'h0C
`define OP_COPY_IW     5'h0D
`define OP_COPY_WM     5'h0E
`define OP_IDLE        5'h0F
`define OP_OR_MW       5'h10
`define OP_OR_IW       5'h11
`define OP_OR_WB       5'h12
`define OP_POP_BACK    5'h13
`define OP_POP_VALUE   5'h14
`define OP_IRQ_EXIT    5'h15

`endif

// file: hdl/mcu_exec_core.v
// Operation
// - kick clears watchdog, timeout and sleep flags
// - both prekicks together clear watchdog and flags
// - lone prekick only records that it ran
// - invert byte in memory, update null flag
// - invert into working register, memory kept
// - low nibble plus six when above nine or half carry set
// - high nibble adjust sets carry, else kept
// - adjust result to memory, only carry changes
// - subtract one to memory or working register
// - add one to memory or working register
// - sleep stops, pc plus one, sleep flag set, timeout flag cleared
// - sleep keeps data, clears watchdog and prescaler
// - branch loads pc from instruction, no flags
// - copy ops move bytes without flag change
// - idle only advances pc
// - or into working register updates null flag
// - or writeback stores result in memory
// - pop back restores pc in two cycles
// - pop with value also loads working register
// - irq exit pops pc and enables interrupts
// - pc low destination adds one instruction cycle
`timescale 1ns/1ns
`include "mcu_exec_regs.vh"

module mcu_exec_core #(
    parameter MEM_DEPTH = 128,
    parameter PRESC_W   = 8,
    parameter WD_W      = 8
) (
    input  wire        clock,
    input  wire        rst_n,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         global_irq_enable,
    output reg         clock_run
);

    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_EXEC  = 2'h1;
    localparam [1:0] ST_SLEEP = 2'h2;
    localparam [1:0] RESP_OK  = 2'h0;
    localparam [1:0] RESP_ERR = 2'h2;

    reg  [7:0]  dmem [0:MEM_DEPTH-1];
    reg  [10:0] stk  [0:3];

    reg  [1:0]         state_r;
    reg  [3:0]         cyc_r;
    reg  [3:0]         last_r;
    reg  [31:0]        ir_r;
    reg  [7:0]         working_register_r;
    reg                carry_r;
    reg                half_carry_flag_r;
    reg                result_null_flag_r;
    reg                timeout_flag_r;
    reg                sleep_flag_r;
    reg  [10:0]        pc_r;
    reg  [2:0]         sp_r;
    reg                pre_a_r;
    reg                pre_b_r;
    reg  [PRESC_W-1:0] presc_r;
    reg  [WD_W-1:0]    watchdog_counter_r;
    reg                wd_en_r;

    wire [4:0]  ir_op   = ir_r[`ISS_OP_HI:`ISS_OP_LO];
    wire [6:0]  ir_addr = ir_r[`ISS_ADDR_HI:`ISS_ADDR_LO];
    wire [7:0]  ir_imm  = ir_r[`ISS_IMM_HI:`ISS_IMM_LO];
    wire [10:0] ir_tgt  = ir_r[`ISS_TGT_HI:`ISS_TGT_LO];
    wire        commit  = (state_r == ST_EXEC) && (cyc_r == last_r);
    wire        idle    = (state_r == ST_IDLE);

    wire        aw_hs   = s_axi_awvalid && s_axi_awready;
    wire        ar_hs   = s_axi_arvalid && s_axi_arready;
    wire [11:0] wa      = s_axi_awaddr;
    wire [11:0] ra      = s_axi_araddr;
    wire        wa_mem  = (wa[11:9] == `MEM_BASE_HI);
    wire        ra_mem  = (ra[11:9] == `MEM_BASE_HI);
    wire [6:0]  wa_idx  = wa[8:2];
    wire [6:0]  ra_idx  = ra[8:2];
    wire [4:0]  iss_op  = s_axi_wdata[`ISS_OP_HI:`ISS_OP_LO];
    wire        iss_pcl = (s_axi_wdata[`ISS_ADDR_HI:`ISS_ADDR_LO]
                           == `PC_LOW_INDEX);
    wire        full_wr = (s_axi_wstrb == 4'hF);

    wire        wd_tick = wd_en_r && (&presc_r);
    wire        wd_wrap = wd_tick && (&watchdog_counter_r);

    // data memory read with the pc low alias
    function [7:0] rd_byte;
        input [6:0]  idx;
        input [7:0]  mem_val;
        input [10:0] pc;
        begin
            if (idx == `PC_LOW_INDEX)
                rd_byte = pc[7:0];
            else
                rd_byte = mem_val;
        end
    endfunction

    // memory-destination ops that land in the pc low byte take two cycles
    function writes_mem;
        input [4:0] op;
        begin
            case (op)
                `OP_INVERT, `OP_BCD_ADJUST, `OP_SUB_ONE, `OP_ADD_ONE,
                `OP_COPY_WM, `OP_OR_WB: writes_mem = 1'b1;
                default: writes_mem = 1'b0;
            endcase
        end
    endfunction

    wire [7:0] src = rd_byte(ir_addr, dmem[ir_addr], pc_r);

    reg  [7:0] res;
    reg        wr_m;
    reg        wr_w;
    reg        upd_z;
    reg        bcd_c;
    reg        upd_c;
    reg  [4:0] lo_s;
    reg  [4:0] hi_s;

    always @*
    begin
        res   = 8'h00;
        wr_m  = 1'b0;
        wr_w  = 1'b0;
        upd_z = 1'b0;
        upd_c = 1'b0;
        lo_s  = {1'b0, working_register_r[3:0]};
        if (lo_s > `BCD_LIMIT || half_carry_flag_r)
            lo_s = lo_s + `BCD_STEP;
        hi_s  = {1'b0, working_register_r[7:4]} + {4'h0, lo_s[4]};
        bcd_c = carry_r;
        if (hi_s > `BCD_LIMIT || carry_r)
        begin
            hi_s  = hi_s + `BCD_STEP;
            bcd_c = 1'b1;
        end
        case (ir_op)
            `OP_INVERT:
            begin
                res = ~src;
                wr_m = 1'b1;
                upd_z = 1'b1;
            end
            `OP_INVERT_W:
            begin
                res = ~src;
                wr_w = 1'b1;
                upd_z = 1'b1;
            end
            `OP_BCD_ADJUST:
            begin
                res = {hi_s[3:0], lo_s[3:0]};
                wr_m = 1'b1;
                upd_c = 1'b1;
            end
            `OP_SUB_ONE, `OP_SUB_ONE_W:
            begin
                res = src - 8'h01;
                wr_m = (ir_op == `OP_SUB_ONE);
                wr_w = (ir_op == `OP_SUB_ONE_W);
                upd_z = 1'b1;
            end
            `OP_ADD_ONE, `OP_ADD_ONE_W:
            begin
                res = src + 8'h01;
                wr_m = (ir_op == `OP_ADD_ONE);
                wr_w = (ir_op == `OP_ADD_ONE_W);
                upd_z = 1'b1;
            end
            `OP_COPY_MW:
            begin
                res = src;
                wr_w = 1'b1;
            end
            `OP_COPY_IW, `OP_POP_VALUE:
            begin
                res = ir_imm;
                wr_w = 1'b1;
            end
            `OP_COPY_WM:
            begin
                res = working_register_r;
                wr_m = 1'b1;
            end
            `OP_OR_MW, `OP_OR_IW:
            begin
                res = working_register_r |
                      ((ir_op == `OP_OR_IW) ? ir_imm : src);
                wr_w = 1'b1;
                upd_z = 1'b1;
            end
            `OP_OR_WB:
            begin
                res = working_register_r | src;
                wr_m = 1'b1;
                upd_z = 1'b1;
            end
            default:
            begin
                res = 8'h00;
            end
        endcase
    end

    wire       pcl_dest = wr_m && (ir_addr == `PC_LOW_INDEX);
    wire       is_pop   = (ir_op == `OP_POP_BACK) || (ir_op == `OP_POP_VALUE)
                          || (ir_op == `OP_IRQ_EXIT);
    wire [1:0] sp_top   = sp_r[1:0] - 2'h1;

    wire       axi_mem_we = aw_hs && idle && full_wr && wa_mem
                            && (wa_idx != `PC_LOW_INDEX);
    wire       push_we    = aw_hs && idle && full_wr
                            && (wa == `OFS_STACK) && (sp_r != 3'h4);

    always @(posedge clock)
    begin
        if (commit && wr_m && !pcl_dest)
            dmem[ir_addr] <= res;
        else if (axi_mem_we)
            dmem[wa_idx] <= s_axi_wdata[7:0];
    end

    always @(posedge clock)
    begin
        if (push_we)
            stk[sp_r[1:0]] <= s_axi_wdata[10:0];
    end

    reg [31:0] rd_val;
    reg        rd_err;

    always @*
    begin
        rd_val = 32'h0000_0000;
        rd_err = 1'b0;
        if (ra_mem)
            rd_val = {24'h000000, rd_byte(ra_idx, dmem[ra_idx], pc_r)};
        else
        begin
            case (ra)
                `OFS_ISSUE:    rd_val = ir_r;
                `OFS_STATUS:   rd_val = {21'h000000, sp_r, 3'h0,
                                         (last_r == `LAST_TWO),
                                         pre_b_r, pre_a_r,
                                         (state_r == ST_SLEEP), !idle};
                `OFS_FLAGS:    rd_val = {26'h0000000, global_irq_enable,
                                         sleep_flag_r, timeout_flag_r,
                                         result_null_flag_r,
                                         half_carry_flag_r, carry_r};
                `OFS_WORKING:  rd_val = {24'h000000, working_register_r};
                `OFS_PC:       rd_val = {21'h000000, pc_r};
                `OFS_STACK:    rd_val = {21'h000000,
                                         (sp_r == 3'h0) ? 11'h000
                                                        : stk[sp_top]};
                `OFS_WATCHDOG: rd_val = {{(32-WD_W){1'b0}},
                                         watchdog_counter_r};
                `OFS_CTRL:     rd_val = {31'h00000000, wd_en_r};
                default:       rd_err = 1'b1;
            endcase
        end
    end

    reg wr_ok;

    always @*
    begin
        wr_ok = idle && full_wr;
        if (wa == `OFS_CTRL)
            wr_ok = full_wr;
        else if (wa == `OFS_ISSUE || wa == `OFS_FLAGS || wa == `OFS_WORKING
                 || wa == `OFS_PC || wa_mem)
            wr_ok = wr_ok;
        else if (wa == `OFS_STACK)
            wr_ok = wr_ok && (sp_r != 3'h4);
        else
            wr_ok = 1'b0;
    end

    always @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_awready      <= 1'b0;
            s_axi_wready       <= 1'b0;
            s_axi_bvalid       <= 1'b0;
            s_axi_bresp        <= RESP_OK;
            s_axi_arready      <= 1'b0;
            s_axi_rvalid       <= 1'b0;
            s_axi_rresp        <= RESP_OK;
            s_axi_rdata        <= 32'h0000_0000;
            state_r            <= ST_IDLE;
            cyc_r              <= 4'h0;
            last_r             <= `LAST_ONE;
            ir_r               <= 32'h0000_0000;
            working_register_r <= 8'h00;
            carry_r            <= 1'b0;
            half_carry_flag_r  <= 1'b0;
            result_null_flag_r <= 1'b0;
            timeout_flag_r     <= 1'b0;
            sleep_flag_r       <= 1'b0;
            global_irq_enable  <= 1'b0;
            clock_run          <= 1'b1;
            pc_r               <= 11'h000;
            sp_r               <= 3'h0;
            pre_a_r            <= 1'b0;
            pre_b_r            <= 1'b0;
            presc_r            <= {PRESC_W{1'b0}};
            watchdog_counter_r <= {WD_W{1'b0}};
            wd_en_r            <= `CTL_RESET;
        end
        else
        begin
            // bus handshakes: take address and data together
            s_axi_awready <= !s_axi_awready && !s_axi_bvalid
                             && s_axi_awvalid && s_axi_wvalid;
            s_axi_wready  <= !s_axi_awready && !s_axi_bvalid
                             && s_axi_awvalid && s_axi_wvalid;
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (aw_hs)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OK : RESP_ERR;
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                             && s_axi_arvalid;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (ar_hs)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_val;
                s_axi_rresp  <= rd_err ? RESP_ERR : RESP_OK;
            end

            // watchdog prescaler and counter
            if (wd_en_r)
                presc_r <= presc_r + {{(PRESC_W-1){1'b0}}, 1'b1};
            if (wd_tick)
                watchdog_counter_r <= watchdog_counter_r
                                      + {{(WD_W-1){1'b0}}, 1'b1};

            if (state_r == ST_EXEC)
                cyc_r <= cyc_r + 4'h1;

            // software writes
            if (aw_hs && wr_ok)
            begin
                case (wa)
                    `OFS_ISSUE:
                    begin
                        ir_r    <= s_axi_wdata;
                        state_r <= ST_EXEC;
                        cyc_r   <= 4'h0;
                        if ((writes_mem(iss_op) && iss_pcl)
                            || iss_op == `OP_BRANCH
                            || iss_op == `OP_POP_BACK
                            || iss_op == `OP_POP_VALUE
                            || iss_op == `OP_IRQ_EXIT)
                            last_r <= `LAST_TWO;
                        else
                            last_r <= `LAST_ONE;
                    end
                    `OFS_FLAGS:
                    begin
                        carry_r            <= s_axi_wdata[`FLG_CARRY];
                        half_carry_flag_r  <= s_axi_wdata[`FLG_HALF];
                        result_null_flag_r <= s_axi_wdata[`FLG_NULL];
                        global_irq_enable  <= s_axi_wdata[`FLG_IRQ_EN];
                    end
                    `OFS_WORKING: working_register_r <= s_axi_wdata[7:0];
                    `OFS_PC:      pc_r <= s_axi_wdata[10:0];
                    `OFS_STACK:   sp_r <= sp_r + 3'h1;
                    `OFS_CTRL:
                    begin
                        wd_en_r <= s_axi_wdata[`CTL_WD_EN];
                        if (s_axi_wdata[`CTL_WAKE] && state_r == ST_SLEEP)
                        begin
                            state_r   <= ST_IDLE;
                            clock_run <= 1'b1;
                        end
                    end
                    default:
                    begin
                        if (wa_mem && wa_idx == `PC_LOW_INDEX)
                            pc_r <= {pc_r[10:8], s_axi_wdata[7:0]};
                    end
                endcase
            end

            // instruction retire
            if (commit)
            begin
                state_r <= ST_IDLE;
                if (wr_w)
                    working_register_r <= res;
                if (upd_z)
                    result_null_flag_r <= (res == 8'h00);
                if (upd_c)
                    carry_r <= bcd_c;
                if (pcl_dest)
                    pc_r <= {pc_r[10:8], res};
                else if (ir_op == `OP_BRANCH)
                    pc_r <= ir_tgt;
                else if (is_pop)
                begin
                    pc_r <= stk[sp_top];
                    if (sp_r != 3'h0)
                        sp_r <= sp_r - 3'h1;
                end
                else
                    pc_r <= pc_r + 11'h001;
                case (ir_op)
                    `OP_KICK:
                    begin
                        watchdog_counter_r <= {WD_W{1'b0}};
                        timeout_flag_r     <= 1'b0;
                        sleep_flag_r       <= 1'b0;
                    end
                    `OP_PREKICK_A, `OP_PREKICK_B:
                    begin
                        if ((ir_op == `OP_PREKICK_A && pre_b_r)
                            || (ir_op == `OP_PREKICK_B && pre_a_r))
                        begin
                            watchdog_counter_r <= {WD_W{1'b0}};
                            timeout_flag_r     <= 1'b0;
                            sleep_flag_r       <= 1'b0;
                            pre_a_r            <= 1'b0;
                            pre_b_r            <= 1'b0;
                        end
                        else if (ir_op == `OP_PREKICK_A)
                            pre_a_r <= 1'b1;
                        else
                            pre_b_r <= 1'b1;
                    end
                    `OP_SLEEP:
                    begin
                        state_r            <= ST_SLEEP;
                        clock_run          <= 1'b0;
                        sleep_flag_r       <= 1'b1;
                        timeout_flag_r     <= 1'b0;
                        watchdog_counter_r <= {WD_W{1'b0}};
                        presc_r            <= {PRESC_W{1'b0}};
                    end
                    `OP_IRQ_EXIT: global_irq_enable <= 1'b1;
                    default:      global_irq_enable <= global_irq_enable;
                endcase
            end

            // watchdog overflow wins over a same-cycle kick but not a sleep, and wakes
            if (wd_wrap && !(commit && ir_op == `OP_SLEEP))
            begin
                timeout_flag_r <= 1'b1;
                if (state_r == ST_SLEEP)
                begin
                    state_r   <= ST_IDLE;
                    clock_run <= 1'b1;
                end
            end
        end
    end

endmodule // mcu_exec_core

// file: tb/mcu_exec_sva.sv
`timescale 1ns/1ns
module mcu_exec_sva (
    input wire        clock,
    input wire        rst_n,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        global_irq_enable
);
    reg [3:0] since_wr_r;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // cycles since the last accepted write
    always @(posedge clock or negedge rst_n)
        if (!rst_n)
            since_wr_r <= 4'hF;
        else if (s_axi_awvalid && s_axi_awready)
            since_wr_r <= 4'h0;
        else if (since_wr_r != 4'hF)
            since_wr_r <= since_wr_r + 4'h1;
    a_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready)
        else $error("write ready split");
    a_aw_pulse: assert property (wr_take |=> !s_axi_awready)
        else $error("write ready held");
    a_b_follow: assert property (wr_take |=> s_axi_bvalid)
        else $error("write response late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_follow: assert property (rd_take |=> s_axi_rvalid)
        else $error("read data late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ar_pulse: assert property (rd_take |=> !s_axi_arready)
        else $error("read ready held");
    a_irq_cause: assert property ($rose(global_irq_enable) |->
        since_wr_r <= 4'hA)
        else $error("irq enable without cause");
endmodule // mcu_exec_sva

// file: tb/testbench.sv
`timescale 1ns/1ns
`include "mcu_exec_regs.vh"
module testbench;
    reg         clock, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg         s_axi_arvalid, s_axi_rready;
    reg  [11:0] s_axi_awaddr, s_axi_araddr;
    reg  [31:0] s_axi_wdata, seed;
    reg  [7:0]  v, nv;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire        s_axi_rvalid, global_irq_enable, clock_run;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer     err_count, n_tests, i;
    reg  [33:0] exp_q[$];
    reg  [1:0]  er;
    mcu_exec_core #(.PRESC_W(2), .WD_W(3)) mcu_exec_core_inst (
        .clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .global_irq_enable, .clock_run);
    always #20 clock = ~clock;
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [11:0] m(input [6:0] k);
        m = {`MEM_BASE_HI, k, 2'b00};
    endfunction
    task final_report;
        begin
            $display("tests %0d errors %0d", n_tests, err_count);
            if (err_count == 0 && n_tests > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task check(input [33:0] seen, input [33:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp)
            begin
                err_count = err_count + 1;
                $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    task hang;
        if (i >= 50)
        begin
            err_count = err_count + 1;
            final_report;
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            i = 0;
            do @(posedge clock); while (!s_axi_awready && ++i < 50);
            s_axi_awvalid <= 1'b0;
            s_axi_wvalid <= 1'b0;
            @(posedge clock);
            s_axi_bready <= 1'b1;
            do @(posedge clock); while (!s_axi_bvalid && ++i < 50);
            s_axi_bready <= 1'b0;
            check(s_axi_bresp, er);
            hang;
        end
    endtask
    task rd(input [11:0] a, input [31:0] e);
        begin
            exp_q.push_back({er, e});
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            i = 0;
            do @(posedge clock); while (!s_axi_arready && ++i < 50);
            s_axi_arvalid <= 1'b0;
            @(posedge clock);
            s_axi_rready <= 1'b1;
            do @(posedge clock); while (!s_axi_rvalid && ++i < 50);
            s_axi_rready <= 1'b0;
            hang;
        end
    endtask
    // issue one instruction and let it retire
    task op(input [4:0] c, input [6:0] a, input [10:0] t);
        begin
            wr(`OFS_ISSUE, {5'h0, t, 1'b0, a, 3'h0, c});
            repeat (10) @(posedge clock);
        end
    endtask
    always @(posedge clock)
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    initial
    begin
        {clock, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 26'h0;
        s_axi_wdata = 32'h0;
        err_count = 0;
        n_tests = 0;
        seed = 32'h143A5;
        er = 2'h0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        wr(`OFS_CTRL, 32'h0);
        seed = lfsr(seed);
        v = seed[7:0];
        nv = ~v;
        op(`OP_COPY_IW, 7'h0, {3'h0, v});
        rd(`OFS_WORKING, {24'h0, v});
        op(`OP_COPY_WM, 7'h5, 11'h0);
        op(`OP_INVERT, 7'h5, 11'h0);
        rd(m(5), {24'h0, nv});
        rd(`OFS_FLAGS, {29'h0, nv == 8'h00, 2'h0});
        op(`OP_INVERT_W, 7'h5, 11'h0);
        rd(`OFS_WORKING, {24'h0, v});
        rd(m(5), {24'h0, nv});
        wr(m(5), 32'hFF);
        op(`OP_ADD_ONE_W, 7'h5, 11'h0);
        rd(`OFS_WORKING, 32'h0);
        rd(`OFS_FLAGS, 32'h4);
        op(`OP_SUB_ONE, 7'h5, 11'h0);
        rd(m(5), 32'hFE);
        rd(`OFS_FLAGS, 32'h0);
        op(`OP_SUB_ONE_W, 7'h5, 11'h0);
        rd(`OFS_WORKING, 32'hFD);
        op(`OP_ADD_ONE, 7'h5, 11'h0);
        rd(m(5), 32'hFF);
        op(`OP_COPY_IW, 7'h0, 11'h30);
        wr(m(6), 32'h5);
        op(`OP_OR_MW, 7'h6, 11'h0);
        rd(`OFS_WORKING, 32'h35);
        op(`OP_OR_IW, 7'h0, 11'h40);
        op(`OP_OR_WB, 7'h6, 11'h0);
        rd(m(6), 32'h75);
        wr(`OFS_WORKING, 32'h9A);
        op(`OP_BCD_ADJUST, 7'h7, 11'h0);
        rd(m(7), 32'h0);
        rd(`OFS_FLAGS, 32'h1);
        wr(`OFS_FLAGS, 32'h2);
        wr(`OFS_WORKING, 32'h12);
        op(`OP_BCD_ADJUST, 7'h7, 11'h0);
        rd(m(7), 32'h18);
        op(`OP_BRANCH, 7'h0, 11'h123);
        rd(`OFS_PC, 32'h123);
        op(`OP_IDLE, 7'h0, 11'h0);
        rd(`OFS_PC, 32'h124);
        wr(`OFS_STACK, 32'h55);
        op(`OP_POP_VALUE, 7'h0, 11'h3C);
        rd(`OFS_PC, 32'h55);
        rd(`OFS_WORKING, 32'h3C);
        wr(`OFS_STACK, 32'h66);
        op(`OP_IRQ_EXIT, 7'h0, 11'h0);
        rd(`OFS_PC, 32'h66);
        check(global_irq_enable, 32'h1);
        wr(`OFS_STACK, 32'h77);
        op(`OP_POP_BACK, 7'h0, 11'h0);
        rd(`OFS_PC, 32'h77);
        rd(`OFS_STATUS, 32'h10);
        rd(`OFS_FLAGS, 32'h22);
        op(`OP_COPY_WM, 7'h2, 11'h0);
        rd(`OFS_PC, 32'h3C);
        rd(`OFS_STATUS, 32'h10);
        op(`OP_SLEEP, 7'h0, 11'h0);
        check(clock_run, 32'h0);
        rd(`OFS_FLAGS, 32'h32);
        rd(`OFS_PC, 32'h3D);
        rd(`OFS_WORKING, 32'h3C);
        wr(`OFS_CTRL, 32'h2);
        op(`OP_PREKICK_A, 7'h0, 11'h0);
        rd(`OFS_FLAGS, 32'h32);
        rd(`OFS_STATUS, 32'h4);
        op(`OP_PREKICK_B, 7'h0, 11'h0);
        rd(`OFS_FLAGS, 32'h22);
        rd(`OFS_STATUS, 32'h0);
        wr(`OFS_CTRL, 32'h1);
        repeat (40) @(posedge clock);
        rd(`OFS_FLAGS, 32'h2A);
        wr(`OFS_CTRL, 32'h0);
        op(`OP_SLEEP, 7'h0, 11'h0);
        rd(`OFS_FLAGS, 32'h32);
        rd(`OFS_WATCHDOG, 32'h0);
        wr(`OFS_CTRL, 32'h3);
        check(clock_run, 32'h1);
        repeat (40) @(posedge clock);
        rd(`OFS_FLAGS, 32'h3A);
        wr(`OFS_CTRL, 32'h0);
        op(`OP_KICK, 7'h0, 11'h0);
        rd(`OFS_FLAGS, 32'h22);
        rd(`OFS_WATCHDOG, 32'h0);
        er = 2'h2;
        wr(12'h0F0, 32'h0);
        rd(12'h0F0, 32'h0);
        final_report;
    end
endmodule // testbench
bind mcu_exec_core mcu_exec_sva mcu_exec_sva_inst (
    .clock, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .global_irq_enable);
